/* core/axhib_defs.vh */
// Constants for the axis-select and hibernate control register block.
// Assumes inclusion by bare name from the core modules only.
`ifndef AXHIB_DEFS_VH
`define AXHIB_DEFS_VH

`define AXHIB_CFG5_ADDR 8'h19
`define AXHIB_CFG5_RESET 8'h00
`define AXHIB_BIT_HIB 0
`define AXHIB_BIT_ZSKIP 1
`define AXHIB_BIT_YSKIP 2
`define AXHIB_BIT_XSKIP 3
`define AXHIB_BIT_MAGEN 4
`define AXHIB_CFG5_WMASK 8'h1F
`define AXHIB_IRQCFG_RESET 2'h1
`define AXHIB_X_LSB 8'h04
`define AXHIB_X_MSB 8'h05
`define AXHIB_Y_LSB 8'h06
`define AXHIB_Y_MSB 8'h07
`define AXHIB_Z_LSB 8'h08
`define AXHIB_Z_MSB 8'h09
`define AXHIB_MAG_LSB 8'h0A
`define AXHIB_MAG_MSB 8'h0B
`define AXHIB_MODE_MAG 1'b1

`endif

/* core/axhib_magnitude.v */
// Vector magnitude engine: 12-bit estimate of |(x,y,z)| per sample.
// Assumes signed 12-bit axis inputs and a one-cycle sample strobe.
`timescale 1ns/1ps
module axhib_magnitude #(
  parameter DW = 12
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  input wire ce_i,
  // Control
  input wire enable_i,
  input wire sample_i,
  // Axis data
  input wire [DW-1:0] x_i,
  input wire [DW-1:0] y_i,
  input wire [DW-1:0] z_i,
  // Result
  output reg [DW-1:0] mag_o,
  output reg valid_o
);
  function [DW-1:0] absval;
    input [DW-1:0] v;
    begin
      absval = v[DW-1] ? (~v + {{(DW-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  wire [DW-1:0] ax = absval(x_i);
  wire [DW-1:0] ay = absval(y_i);
  wire [DW-1:0] az = absval(z_i);
  wire [DW-1:0] mx = (ax > ay) ? ((ax > az) ? ax : az)
                               : ((ay > az) ? ay : az);
  // Max plus half of the rest: cheap, no multiplier or square root
  wire [DW+1:0] rest = {2'b00, ax} + {2'b00, ay} + {2'b00, az}
                       - {2'b00, mx};
  wire [DW+1:0] est = {2'b00, mx} + (rest >> 1);
  wire ovf = |est[DW+1:DW];

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mag_o <= {DW{1'b0}};
      valid_o <= 1'b0;
    end else if (ce_i) begin
      valid_o <= 1'b0;
      if (enable_i && sample_i) begin
        mag_o <= ovf ? {DW{1'b1}} : est[DW-1:0];
        valid_o <= 1'b1;
      end
    end
  end
endmodule // axhib_magnitude

/* core/axhib_ctrl.v */
// Axis-select and hibernate control: configuration register five,
// burst-read address stepping and hibernate entry and exit.
// Assumes a host-interface front end that gives byte-wide register
// strobes on ref_clk_i; pins arrive asynchronously.
// How it works
// - Magnitude enable computes a 12-bit magnitude each sample; clear stops it.
// - Magnitude bytes are in the burst range only while enable is one.
// - Change detection takes magnitude as input when its mode is one.
// - X skip bit three drops X from the burst range.
// - Y skip bit two drops Y from the burst range.
// - Z skip bit one drops Z from the burst range.
// - Hibernate bit zero enters hibernate when strap is low, losing volatile registers.
// - Strap low: wake only on a wake-pin level change from hibernate entry time.
// - Strap high: motion pin high leaves hibernate through the one-cycle boot state to active.
// - Strap high: motion pin low enters hibernate.
// - Interrupt driver and polarity survive soft reset, lost on hibernate.
`timescale 1ns/1ps
`include "axhib_defs.vh"
module axhib_ctrl #(
  parameter DW = 12,
  parameter AW = 8
) (
  // Clock, reset, enable
  input wire ref_clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire soft_reset_i,
  // Register access
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [AW-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Burst-read address stepping
  input wire [AW-1:0] burst_addr_i,
  output reg [AW-1:0] burst_next_o,
  // Sampled axis data
  input wire sample_i,
  input wire [DW-1:0] x_data_i,
  input wire [DW-1:0] y_data_i,
  input wire [DW-1:0] z_data_i,
  output wire [7:0] magnitude_low_byte_o,
  output wire [7:0] magnitude_high_byte_o,
  output wire magnitude_valid_o,
  // Change detection source
  input wire change_detect_mode_i,
  output reg [DW-1:0] change_detect_src_o,
  // Interrupt pin settings
  input wire irq_cfg_wr_i,
  input wire [1:0] irq_cfg_i,
  output wire irq_driver_type_o,
  output wire irq_polarity_o,
  // Pins and power state
  input wire boot_strap_select_i,
  input wire wake_pin_i,
  input wire motion_detect_level_pin_i,
  output wire hibernate_o,
  output reg boot_start_o,
  output wire motion_boot_o
);
  localparam ST_RUN = 2'b00;
  localparam ST_HIB = 2'b01;
  localparam ST_BOOT = 2'b10;

  reg [7:0] cfg5_r;
  reg [1:0] irqcfg_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg wake_ref_r;
  reg motion_boot_r;
  wire [2:0] pin_raw;
  wire [2:0] pin_q;
  wire [DW-1:0] mag;

  wire mag_en = cfg5_r[`AXHIB_BIT_MAGEN];
  wire x_skip = cfg5_r[`AXHIB_BIT_XSKIP];
  wire y_skip = cfg5_r[`AXHIB_BIT_YSKIP];
  wire z_skip = cfg5_r[`AXHIB_BIT_ZSKIP];
  wire hib_req = cfg5_r[`AXHIB_BIT_HIB];
  wire wake_q = pin_q[0];
  wire mot_q = pin_q[1];
  wire strap_q = pin_q[2];

  // Two flip-flops per pin; only the second stage is read
  assign pin_raw = {boot_strap_select_i, motion_detect_level_pin_i,
                    wake_pin_i};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else if (ce_i) begin
          s1_r <= pin_raw[g];
          s2_r <= s1_r;
        end
      end
      assign pin_q[g] = s2_r;
    end
  endgenerate

  // Register is included only when its enable condition holds
  function incl;
    input [AW-1:0] a;
    input xs;
    input ys;
    input zs;
    input me;
    begin
      case (a)
        `AXHIB_X_LSB, `AXHIB_X_MSB: incl = !xs;
        `AXHIB_Y_LSB, `AXHIB_Y_MSB: incl = !ys;
        `AXHIB_Z_LSB, `AXHIB_Z_MSB: incl = !zs;
        `AXHIB_MAG_LSB, `AXHIB_MAG_MSB: incl = me;
        default: incl = 1'b0;
      endcase
    end
  endfunction

  // Next included output register after the current burst address
  integer i;
  reg found;
  reg [AW-1:0] cand;
  always @* begin
    found = 1'b0;
    cand = {AW{1'b0}};
    burst_next_o = burst_addr_i + {{(AW-1){1'b0}}, 1'b1};
    if (burst_addr_i < `AXHIB_MAG_MSB) begin
      for (i = 1; i <= 8; i = i + 1) begin
        cand = burst_addr_i + i[AW-1:0];
        if (!found && cand >= `AXHIB_X_LSB && cand <= `AXHIB_MAG_MSB &&
            incl(cand, x_skip, y_skip, z_skip, mag_en)) begin
          found = 1'b1;
          burst_next_o = cand;
        end
      end
      // Nothing left in the output block: leave it
      if (!found && burst_addr_i >= `AXHIB_X_LSB - 8'h01)
        burst_next_o = `AXHIB_MAG_MSB + 8'h01;
    end
  end

  // Power-state sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (strap_q ? !mot_q : hib_req)
          state_nxt = ST_HIB;
      end
      ST_HIB: begin
        if (strap_q ? mot_q : (wake_q != wake_ref_r))
          state_nxt = ST_BOOT;
      end
      ST_BOOT: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_RUN;
      wake_ref_r <= 1'b0;
      motion_boot_r <= 1'b0;
      boot_start_o <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      boot_start_o <= (state_nxt == ST_BOOT);
      // Wake level frozen at entry; either edge away from it wakes
      if (state_r == ST_RUN && state_nxt == ST_HIB)
        wake_ref_r <= wake_q;
      if (state_nxt == ST_BOOT)
        motion_boot_r <= strap_q;
      else if (state_nxt == ST_HIB)
        motion_boot_r <= 1'b0;
    end
  end

  assign hibernate_o = (state_r == ST_HIB);
  assign motion_boot_o = motion_boot_r;

  // Configuration register five; wiped on hibernate entry
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cfg5_r <= `AXHIB_CFG5_RESET;
    end else if (ce_i) begin
      if (state_r != ST_RUN || soft_reset_i)
        cfg5_r <= `AXHIB_CFG5_RESET;
      else if (reg_wr_i && reg_addr_i == `AXHIB_CFG5_ADDR)
        cfg5_r <= reg_wdata_i & `AXHIB_CFG5_WMASK;
    end
  end

  // Interrupt pin settings: not touched by soft reset
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irqcfg_r <= `AXHIB_IRQCFG_RESET;
    end else if (ce_i) begin
      if (state_r != ST_RUN)
        irqcfg_r <= `AXHIB_IRQCFG_RESET;
      else if (irq_cfg_wr_i)
        irqcfg_r <= irq_cfg_i;
    end
  end

  assign irq_driver_type_o = irqcfg_r[1];
  assign irq_polarity_o = irqcfg_r[0];

  axhib_magnitude #(
    .DW(DW)
  ) u_mag (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .enable_i(mag_en && !hibernate_o),
    .sample_i(sample_i),
    .x_i(x_data_i),
    .y_i(y_data_i),
    .z_i(z_data_i),
    .mag_o(mag),
    .valid_o(magnitude_valid_o)
  );

  assign magnitude_low_byte_o = mag[7:0];
  assign magnitude_high_byte_o = {{(16-DW){1'b0}}, mag[DW-1:8]};

  // Change detection source select and register readback
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      change_detect_src_o <= {DW{1'b0}};
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (change_detect_mode_i == `AXHIB_MODE_MAG)
        change_detect_src_o <= mag;
      else
        change_detect_src_o <= x_data_i;
      if (reg_rd_i && reg_addr_i == `AXHIB_CFG5_ADDR)
        reg_rdata_o <= cfg5_r;
      else if (reg_rd_i)
        reg_rdata_o <= 8'h00;
    end
  end
endmodule // axhib_ctrl

/* tb/axhib_host_model.sv */
// Host pin model: wake toggle, motion level, boot-delay pacing.
// Assumes delays are counted in ref_clk_i cycles.
`timescale 1ns/1ps
module axhib_host_model #(
  parameter BOOT1 = 40,
  parameter BOOT2 = 60
) (
  // Requests from the bench
  input wire ref_clk_i,
  input wire wake_req_i,
  input wire motion_i,
  // Pins and pacing
  output reg wake_pin_o,
  output reg motion_o,
  output wire ready_o
);
  integer wait_r = 0;
  assign ready_o = (wait_r == 0);
  initial begin
    wake_pin_o = 1'b1;
    motion_o = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    motion_o <= motion_i;
    if (wake_req_i) begin
      wake_pin_o <= ~wake_pin_o;
      wait_r <= BOOT1;
    end else if (motion_i && !motion_o) begin
      wait_r <= BOOT2;
    end else if (wait_r != 0) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule // axhib_host_model

/* tb/axhib_ctrl_monitor.sv */
// Port checker for axhib_ctrl, bound below.
// Assumes pin changes settle through the two-stage synchronisers.
`timescale 1ns/1ps
module axhib_chk (
  // Clock and control
  input wire ref_clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire soft_reset_i,
  input wire irq_cfg_wr_i,
  input wire sample_i,
  input wire [7:0] burst_addr_i,
  // Pins
  input wire boot_strap_select_i,
  input wire wake_pin_i,
  input wire motion_detect_level_pin_i,
  // Outputs watched
  input wire [7:0] burst_next_o,
  input wire [7:0] magnitude_high_byte_o,
  input wire magnitude_valid_o,
  input wire irq_driver_type_o,
  input wire irq_polarity_o,
  input wire hibernate_o,
  input wire boot_start_o,
  input wire motion_boot_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);
  sequence s_mot_hi;
    (boot_strap_select_i && motion_detect_level_pin_i) [*6];
  endsequence
  sequence s_mot_lo;
    (boot_strap_select_i && !motion_detect_level_pin_i) [*6];
  endsequence
  sequence s_wake_quiet;
    (!boot_strap_select_i && hibernate_o && $stable(wake_pin_i)) [*6];
  endsequence
  a_mag_after_sample: assert property (
    magnitude_valid_o |-> $past(sample_i))
    else $error("magnitude valid without sample");
  a_mag_twelve_bit: assert property (
    magnitude_high_byte_o[7:4] == 4'h0)
    else $error("magnitude wider than twelve bits");
  a_wake_hold_hib: assert property (
    s_wake_quiet |=> hibernate_o)
    else $error("woke without edge");
  a_boot_leaves_hib: assert property (
    boot_start_o |-> ##[0:2] !hibernate_o)
    else $error("boot while still asleep");
  a_boot_one_pulse: assert property (
    boot_start_o |=> !boot_start_o)
    else $error("boot pulse longer than one cycle");
  a_motion_wake: assert property (
    s_mot_hi |=> !hibernate_o && motion_boot_o)
    else $error("motion high did not wake");
  a_motion_sleep: assert property (
    s_mot_lo |=> hibernate_o)
    else $error("motion low did not sleep");
  a_irq_soft_keep: assert property (
    soft_reset_i && !irq_cfg_wr_i && !hibernate_o |=>
    $stable({irq_driver_type_o, irq_polarity_o}))
    else $error("irq settings lost on soft reset");
  a_irq_hib_lost: assert property (
    $rose(hibernate_o) |-> ##[0:2] (!irq_driver_type_o && irq_polarity_o))
    else $error("irq settings kept in hibernate");
  a_burst_tail: assert property (
    burst_addr_i >= 8'h0B |-> burst_next_o == burst_addr_i + 8'h01)
    else $error("burst tail step");
  a_burst_forward: assert property (
    burst_addr_i < 8'h0B |-> burst_next_o > burst_addr_i &&
    burst_next_o <= 8'h0C)
    else $error("burst step out of range");
endmodule // axhib_chk
bind axhib_ctrl axhib_chk u_chk (.*);

/* tb/tb_top.sv */
// Self-checking bench for axhib_ctrl with host pin model.
// Assumes ce_i always high; strobes driven after rising edges.
`timescale 1ns/1ps
module tb_top;
  reg clk, rstn, srst, wr, rd, smp, cdm, iwr, strap, wreq, mreq;
  reg [7:0] addr, wd, ba, d;
  reg [11:0] xd, yd, zd;
  reg [1:0] icfg;
  wire [7:0] rdat, bn, mlo, mhi;
  wire [11:0] cds;
  wire mval, idrv, ipol, wpin, mpin, hib, boot, mboot, hrdy;
  integer err_total = 0, num_checks = 0, n;
  axhib_ctrl DUT (.ref_clk_i(clk), .resetn_i(rstn), .ce_i(1'b1),
    .soft_reset_i(srst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .burst_addr_i(ba),
    .burst_next_o(bn), .sample_i(smp), .x_data_i(xd), .y_data_i(yd),
    .z_data_i(zd), .magnitude_low_byte_o(mlo), .magnitude_high_byte_o(mhi),
    .magnitude_valid_o(mval), .change_detect_mode_i(cdm),
    .change_detect_src_o(cds), .irq_cfg_wr_i(iwr), .irq_cfg_i(icfg),
    .irq_driver_type_o(idrv), .irq_polarity_o(ipol),
    .boot_strap_select_i(strap), .wake_pin_i(wpin),
    .motion_detect_level_pin_i(mpin), .hibernate_o(hib),
    .boot_start_o(boot), .motion_boot_o(mboot));
  axhib_host_model u_host (.ref_clk_i(clk), .wake_req_i(wreq),
    .motion_i(mreq), .wake_pin_o(wpin), .motion_o(mpin), .ready_o(hrdy));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task wr_reg(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      {wr, addr, wd} <= {1'b1, a, v};
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      {rd, addr} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
    end
  endtask
  task burst(input [7:0] cfg, input [7:0] a, input [7:0] e);
    begin
      wr_reg(8'h19, cfg);
      ba <= a;
      @(posedge clk);
      #1 chk(bn, e);
    end
  endtask
  task pulse_smp;
    begin
      @(posedge clk);
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
      n = 0;
      repeat (4) begin
        #1 if (mval === 1'b1) n = n + 1;
        @(posedge clk);
      end
      #1;
    end
  endtask
  task wake_cycle;
    begin
      @(posedge clk);
      wreq <= 1'b1;
      @(posedge clk);
      wreq <= 1'b0;
      n = 0;
      repeat (8) begin
        @(posedge clk);
        #1 if (boot === 1'b1) n = n + 1;
      end
      chk(n, 1);
      chk({hib, mboot}, 2'h0);
      while (hrdy !== 1'b1) cyc(1);
    end
  endtask
  task t_regs;
    begin
      rd_reg(8'h19);
      chk(d, 8'h00);
      chk({idrv, ipol, hib, mboot}, 4'h4);
      wr_reg(8'h19, 8'hFE);
      rd_reg(8'h19);
      chk(d, 8'h1E);
      rd_reg(8'h1A);
      chk(d, 8'h00);
    end
  endtask
  task t_burst;
    begin
      burst(8'h00, 8'h09, 8'h0C);
      burst(8'h10, 8'h09, 8'h0A);
      burst(8'h08, 8'h03, 8'h06);
      burst(8'h04, 8'h05, 8'h08);
      burst(8'h02, 8'h07, 8'h0C);
      burst(8'h1E, 8'h03, 8'h0A);
      burst(8'h1C, 8'h03, 8'h08);
      burst(8'h0E, 8'h03, 8'h0C);
    end
  endtask
  task t_mag;
    begin
      wr_reg(8'h19, 8'h10);
      {xd, yd, zd, cdm} <= {12'h003, 12'h004, 12'h000, 1'b1};
      pulse_smp;
      chk(n, 1);
      chk({mhi, mlo}, 16'h0005);
      chk(cds, 12'h005);
      wr_reg(8'h19, 8'h00);
      pulse_smp;
      chk(n, 0);
      @(posedge clk);
      cdm <= 1'b0;
      cyc(2);
      #1 chk(cds, 12'h003);
    end
  endtask
  task t_hib_low;
    begin
      @(posedge clk);
      {icfg, iwr} <= {2'h2, 1'b1};
      @(posedge clk);
      {iwr, srst} <= 2'b01;
      @(posedge clk);
      srst <= 1'b0;
      cyc(2);
      #1 chk({idrv, ipol}, 2'h2);
      wr_reg(8'h19, 8'h11);
      cyc(12);
      #1 chk({hib, idrv, ipol}, 3'h5);
      wake_cycle;
      rd_reg(8'h19);
      chk(d, 8'h00);
      wr_reg(8'h19, 8'h01);
      cyc(12);
      #1 chk(hib, 1'b1);
      wake_cycle;
    end
  endtask
  task t_strap_high;
    begin
      @(posedge clk);
      strap <= 1'b1;
      cyc(10);
      #1 chk(hib, 1'b1);
      @(posedge clk);
      mreq <= 1'b1;
      cyc(10);
      #1 chk({hib, mboot}, 2'h1);
      while (hrdy !== 1'b1) cyc(1);
      mreq <= 1'b0;
      cyc(10);
      #1 chk({hib, mboot}, 2'h2);
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rstn, srst, wr, rd, smp, cdm, iwr, strap, wreq, mreq} = 10'h000;
    {addr, wd, ba, xd, yd, zd, icfg} = 62'h0;
    cyc(20);
    rstn <= 1'b1;
    t_regs;
    t_burst;
    t_mag;
    t_hib_low;
    t_strap_high;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    print_verdict;
  end
endmodule // tb_top
